// ===== src/mfrs_decode.sv
// option code decoder: maps a code to a stopping reaction
`timescale 1ns/1ns
`default_nettype none
module mfrs_decode (
    input wire logic [15:0] code,
    input wire logic limit_table,
    output mfrs_pkg::mfrs_react_t react
);
    // table lookup; codes outside the table give a harmless invalid reaction
    always_comb begin
        react = '{mfrs_pkg::MFRS_RAMP_NONE, mfrs_pkg::MFRS_NEXT_STAY, 1'b0, 1'b1}; // R14
        if (!limit_table) begin
            case (code)
                mfrs_pkg::OPT_FREE: begin
                    react = '{mfrs_pkg::MFRS_RAMP_FREE, mfrs_pkg::MFRS_NEXT_STAY,
                              1'b0, 1'b0}; // R2
                end
                mfrs_pkg::OPT_SLOW: begin
                    react = '{mfrs_pkg::MFRS_RAMP_SLOW, mfrs_pkg::MFRS_NEXT_STAY,
                              1'b0, 1'b0}; // R3
                end
                mfrs_pkg::OPT_QUICK: begin
                    react = '{mfrs_pkg::MFRS_RAMP_QUICK, mfrs_pkg::MFRS_NEXT_STAY,
                              1'b0, 1'b0}; // R4
                end
                default: begin
                end
            endcase
        end else begin
            case (code)
                mfrs_pkg::OPT_NONE: begin
                    react = '{mfrs_pkg::MFRS_RAMP_NONE, mfrs_pkg::MFRS_NEXT_STAY,
                              1'b1, 1'b0}; // R6
                end
                mfrs_pkg::OPT_SLOW: begin
                    react = '{mfrs_pkg::MFRS_RAMP_SLOW, mfrs_pkg::MFRS_NEXT_SW_ON_DIS,
                              1'b0, 1'b0}; // R7
                end
                mfrs_pkg::OPT_QUICK: begin
                    react = '{mfrs_pkg::MFRS_RAMP_QUICK, mfrs_pkg::MFRS_NEXT_SW_ON_DIS,
                              1'b0, 1'b0}; // R8
                end
                mfrs_pkg::OPT_SLOW_QSA: begin
                    react = '{mfrs_pkg::MFRS_RAMP_SLOW, mfrs_pkg::MFRS_NEXT_QSTOP_ACT,
                              1'b1, 1'b0}; // R9
                end
                mfrs_pkg::OPT_QUICK_QSA: begin
                    react = '{mfrs_pkg::MFRS_RAMP_QUICK, mfrs_pkg::MFRS_NEXT_QSTOP_ACT,
                              1'b1, 1'b0}; // R10
                end
                default: begin
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ===== src/mfrs_pkg.sv
// package: register map, option codes, reaction types for the fault reaction selector
package mfrs_pkg;
    // object indices as seen by the fieldbus host
    localparam logic [15:0] IDX_DEV_ACTION = 16'h3700;
    localparam logic [15:0] IDX_LIM_ACTION = 16'h3701;
    localparam logic [15:0] IDX_HW_INFO = 16'h4012;
    localparam logic [15:0] IDX_HW_CONFIG = 16'h4013;
    localparam logic [7:0] SUB_COUNT = 8'h00;
    localparam logic [7:0] SUB_FIRST = 8'h01;
    localparam logic [7:0] HW_INFO_SUBS = 8'h01;
    localparam logic [7:0] HW_CONFIG_SUBS = 8'h01;
    // reset values
    localparam logic [15:0] DEV_ACTION_RST = 16'hffff;
    localparam logic [15:0] LIM_ACTION_RST = 16'hffff;
    localparam logic [31:0] HW_CONFIG_RST = 32'h00000000;
    // option codes
    localparam logic [15:0] OPT_NONE = 16'hffff;
    localparam logic [15:0] OPT_FREE = 16'h0000;
    localparam logic [15:0] OPT_SLOW = 16'h0001;
    localparam logic [15:0] OPT_QUICK = 16'h0002;
    localparam logic [15:0] OPT_SLOW_QSA = 16'h0005;
    localparam logic [15:0] OPT_QUICK_QSA = 16'h0006;
    // status and control word bit positions
    localparam int STAT_WARN_BIT = 7;
    localparam int CTRL_QSTOP_BIT = 2;

    typedef enum logic [1:0] {
        MFRS_RAMP_NONE,
        MFRS_RAMP_FREE,
        MFRS_RAMP_SLOW,
        MFRS_RAMP_QUICK
    } mfrs_ramp_t;

    typedef enum logic [1:0] {
        MFRS_NEXT_STAY,
        MFRS_NEXT_SW_ON_DIS,
        MFRS_NEXT_QSTOP_ACT
    } mfrs_next_t;

    // reaction handed to the ramp generators and drive state machine
    typedef struct packed {
        mfrs_ramp_t ramp;
        mfrs_next_t next;
        logic keep_energized;
        logic invalid;
    } mfrs_react_t;

    // object access request from the fieldbus host
    typedef struct packed {
        logic rd;
        logic wr;
        logic [15:0] index;
        logic [7:0] subindex;
        logic [31:0] wdata;
    } mfrs_req_t;
endpackage

// ===== src/mfrs_top.sv
// fault reaction selector: option objects, event latching and reaction output
//
// How it works
// R1: a following or slippage error triggers the deviation option code action unless a limit event rises in the same cycle.
// R2: deviation code 0 frees the motor, drive function disabled.
// R3: deviation code 1 brakes on the mode-dependent slow-down ramp.
// R4: deviation code 2 brakes on the quick-stop ramp.
// R5: limit switch passed sets status warning bit 7 and runs limit action, both in the same cycle.
// R6: limit code -1 takes no stopping action, so homing continues.
// R7: limit code 1 brakes slow-down, then goes to switch-on-disabled.
// R8: limit code 2 brakes quick-stop, then goes to switch-on-disabled.
// R9: limit code 5 brakes slow-down, enters quick-stop-active, stays energized.
// R10: limit code 6 brakes quick-stop, enters quick-stop-active, stays energized.
// R11: entering quick-stop-active leaves control word quick-stop bit untouched.
// R12: host returns to operation-enabled by writing quick-stop bit 0 then 1.
// R13: memory size object reports eeprom bytes, zero when none fitted.
// R14: reserved option codes are invalid and cause no stopping action.
`timescale 1ns/1ns
`default_nettype none
module mfrs_top #(
    parameter int EEPROM_BYTES_W = 32
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire mfrs_pkg::mfrs_req_t req,
    output logic ack,
    output logic err,
    output logic [31:0] rdata,
    input wire logic deviation_err,
    input wire logic limit_passed,
    input wire logic eeprom_present,
    input wire logic [EEPROM_BYTES_W-1:0] eeprom_bytes,
    input wire logic [15:0] ctrl_word_in,
    output logic [15:0] ctrl_word_out,
    input wire logic [15:0] status_in,
    output logic [15:0] status_out,
    input wire logic warn_clear,
    output logic react_valid,
    output mfrs_pkg::mfrs_react_t react,
    output logic [31:0] hw_config
);
    // event inputs come from pins: two-stage synchronisers
    logic [1:0] ev_s1_q, ev_s1_d, ev_s2_q, ev_s2_d, ev_s3_q, ev_s3_d;
    logic [15:0] dev_code_q, dev_code_d, lim_code_q, lim_code_d;
    logic [31:0] hw_cfg_q, hw_cfg_d, rdata_q, rdata_d;
    logic ack_q, ack_d, err_q, err_d, warn_q, warn_d, valid_q, valid_d;
    mfrs_pkg::mfrs_react_t react_q, react_d, dev_react, lim_react;
    logic dev_rise, lim_rise;

    // next values of the synchroniser chain
    always_comb begin
        ev_s1_d = {limit_passed, deviation_err};
        ev_s2_d = ev_s1_q;
        ev_s3_d = ev_s2_q;
    end

    // synchroniser registers
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ev_s1_q <= 2'h0;
            ev_s2_q <= 2'h0;
            ev_s3_q <= 2'h0;
        end else begin
            ev_s1_q <= ev_s1_d;
            ev_s2_q <= ev_s2_d;
            ev_s3_q <= ev_s3_d;
        end
    end

    assign dev_rise = ev_s2_q[0] & ~ev_s3_q[0];
    assign lim_rise = ev_s2_q[1] & ~ev_s3_q[1];

    // code decoders for both tables
    mfrs_decode u_dev_dec (
        .code(dev_code_q),
        .limit_table(1'b0),
        .react(dev_react)
    );
    mfrs_decode u_lim_dec (
        .code(lim_code_q),
        .limit_table(1'b1),
        .react(lim_react)
    );

    // object access, warning flag and reaction selection
    always_comb begin
        dev_code_d = dev_code_q;
        lim_code_d = lim_code_q;
        hw_cfg_d = hw_cfg_q;
        rdata_d = rdata_q;
        ack_d = 1'b0;
        err_d = 1'b0;
        warn_d = warn_q;
        valid_d = 1'b0;
        react_d = react_q;
        if (req.wr) begin
            ack_d = 1'b1;
            if (req.index == mfrs_pkg::IDX_DEV_ACTION && req.subindex == mfrs_pkg::SUB_COUNT) begin
                dev_code_d = req.wdata[15:0];
            end else if (req.index == mfrs_pkg::IDX_LIM_ACTION &&
                         req.subindex == mfrs_pkg::SUB_COUNT) begin
                lim_code_d = req.wdata[15:0];
            end else if (req.index == mfrs_pkg::IDX_HW_CONFIG &&
                         req.subindex == mfrs_pkg::SUB_FIRST) begin
                hw_cfg_d = req.wdata;
            end else begin
                err_d = 1'b1;
            end
        end else if (req.rd) begin
            ack_d = 1'b1;
            rdata_d = 32'h00000000;
            case (req.index)
                mfrs_pkg::IDX_DEV_ACTION: rdata_d = {{16{dev_code_q[15]}}, dev_code_q};
                mfrs_pkg::IDX_LIM_ACTION: rdata_d = {{16{lim_code_q[15]}}, lim_code_q};
                mfrs_pkg::IDX_HW_INFO: begin
                    if (req.subindex == mfrs_pkg::SUB_COUNT) begin
                        rdata_d = {24'h000000, mfrs_pkg::HW_INFO_SUBS};
                    end else if (req.subindex == mfrs_pkg::SUB_FIRST) begin
                        rdata_d = eeprom_present ? 32'(eeprom_bytes) : 32'h00000000; // R13
                    end else begin
                        err_d = 1'b1;
                    end
                end
                mfrs_pkg::IDX_HW_CONFIG: begin
                    if (req.subindex == mfrs_pkg::SUB_COUNT) begin
                        rdata_d = {24'h000000, mfrs_pkg::HW_CONFIG_SUBS};
                    end else if (req.subindex == mfrs_pkg::SUB_FIRST) begin
                        rdata_d = hw_cfg_q;
                    end else begin
                        err_d = 1'b1;
                    end
                end
                default: err_d = 1'b1;
            endcase
        end
        // clear of the warning loses to a new limit event
        if (warn_clear) begin
            warn_d = 1'b0;
        end
        if (lim_rise) begin
            warn_d = 1'b1; // R5
            react_d = lim_react; // R5
            valid_d = ~lim_react.invalid; // R14
        end else if (dev_rise) begin
            react_d = dev_react; // R1
            valid_d = ~dev_react.invalid; // R14
        end
    end

    // object and reaction registers
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            dev_code_q <= mfrs_pkg::DEV_ACTION_RST;
            lim_code_q <= mfrs_pkg::LIM_ACTION_RST;
            hw_cfg_q <= mfrs_pkg::HW_CONFIG_RST;
            rdata_q <= 32'h00000000;
            ack_q <= 1'b0;
            err_q <= 1'b0;
            warn_q <= 1'b0;
            valid_q <= 1'b0;
            react_q <= '{mfrs_pkg::MFRS_RAMP_NONE, mfrs_pkg::MFRS_NEXT_STAY, 1'b0, 1'b0};
        end else begin
            dev_code_q <= dev_code_d;
            lim_code_q <= lim_code_d;
            hw_cfg_q <= hw_cfg_d;
            rdata_q <= rdata_d;
            ack_q <= ack_d;
            err_q <= err_d;
            warn_q <= warn_d;
            valid_q <= valid_d;
            react_q <= react_d;
        end
    end

    assign ack = ack_q;
    assign err = err_q;
    assign rdata = rdata_q;
    assign react_valid = valid_q;
    assign react = react_q;
    assign hw_config = hw_cfg_q;
    // quick-stop bit passes through untouched; host toggles it 0 then 1 itself
    assign ctrl_word_out = ctrl_word_in; // R11 R12
    // warning bit merged into the drive status word
    always_comb begin
        status_out = status_in;
        status_out[mfrs_pkg::STAT_WARN_BIT] = warn_q; // R5
    end

    // checks
    property p_lim_warn;
        @(posedge sys_clk) disable iff (!rst_n) lim_rise |=> warn_q;
    endproperty
    a_lim_warn: assert property (p_lim_warn) else $error("warning not set"); // R5

    property p_dev_react;
        @(posedge sys_clk) disable iff (!rst_n)
            (dev_rise && !lim_rise && !dev_react.invalid)
                |=> (valid_q && react_q == $past(dev_react));
    endproperty
    a_dev_react: assert property (p_dev_react) else $error("deviation reaction lost"); // R1

    property p_dev_free;
        @(posedge sys_clk) disable iff (!rst_n)
            (dev_rise && !lim_rise && dev_code_q == mfrs_pkg::OPT_FREE)
                |=> react_q.ramp == mfrs_pkg::MFRS_RAMP_FREE;
    endproperty
    a_dev_free: assert property (p_dev_free) else $error("code 0 not free"); // R2

    property p_dev_quick;
        @(posedge sys_clk) disable iff (!rst_n)
            (dev_rise && !lim_rise && dev_code_q == mfrs_pkg::OPT_QUICK)
                |=> react_q.ramp == mfrs_pkg::MFRS_RAMP_QUICK;
    endproperty
    a_dev_quick: assert property (p_dev_quick) else $error("code 2 not quick"); // R4

    property p_lim_qsa;
        @(posedge sys_clk) disable iff (!rst_n)
            (lim_rise && lim_code_q == mfrs_pkg::OPT_QUICK_QSA)
                |=> (react_q.next == mfrs_pkg::MFRS_NEXT_QSTOP_ACT && react_q.keep_energized);
    endproperty
    a_lim_qsa: assert property (p_lim_qsa) else $error("code 6 wrong"); // R10

    property p_lim_none;
        @(posedge sys_clk) disable iff (!rst_n)
            (lim_rise && lim_code_q == mfrs_pkg::OPT_NONE)
                |=> react_q.ramp == mfrs_pkg::MFRS_RAMP_NONE;
    endproperty
    a_lim_none: assert property (p_lim_none) else $error("code -1 acted"); // R6

    property p_invalid;
        @(posedge sys_clk) disable iff (!rst_n) valid_q |-> !react_q.invalid;
    endproperty
    a_invalid: assert property (p_invalid) else $error("reserved code acted"); // R14

    property p_ctrl;
        @(posedge sys_clk) disable iff (!rst_n)
            ctrl_word_out[mfrs_pkg::CTRL_QSTOP_BIT] == ctrl_word_in[mfrs_pkg::CTRL_QSTOP_BIT];
    endproperty
    a_ctrl: assert property (p_ctrl) else $error("quick-stop bit altered"); // R11

    property p_dev_slow;
        @(posedge sys_clk) disable iff (!rst_n)
            (dev_rise && !lim_rise && dev_code_q == mfrs_pkg::OPT_SLOW)
                |=> react_q.ramp == mfrs_pkg::MFRS_RAMP_SLOW;
    endproperty
    a_dev_slow: assert property (p_dev_slow) else $error("code 1 not slow"); // R3

    property p_lim_sw_off;
        @(posedge sys_clk) disable iff (!rst_n)
            (lim_rise && (lim_code_q == mfrs_pkg::OPT_SLOW ||
                          lim_code_q == mfrs_pkg::OPT_QUICK))
                |=> (react_q.next == mfrs_pkg::MFRS_NEXT_SW_ON_DIS && valid_q);
    endproperty
    a_lim_sw_off: assert property (p_lim_sw_off) else $error("no switch-on-disabled"); // R7 R8

    property p_lim_slow_qsa;
        @(posedge sys_clk) disable iff (!rst_n)
            (lim_rise && lim_code_q == mfrs_pkg::OPT_SLOW_QSA)
                |=> (react_q.ramp == mfrs_pkg::MFRS_RAMP_SLOW &&
                     react_q.next == mfrs_pkg::MFRS_NEXT_QSTOP_ACT && react_q.keep_energized);
    endproperty
    a_lim_slow_qsa: assert property (p_lim_slow_qsa) else $error("code 5 wrong"); // R9

    property p_mem_none;
        @(posedge sys_clk) disable iff (!rst_n)
            (req.rd && !req.wr && req.index == mfrs_pkg::IDX_HW_INFO &&
             req.subindex == mfrs_pkg::SUB_FIRST && !eeprom_present)
                |=> rdata_q == 32'h00000000;
    endproperty
    a_mem_none: assert property (p_mem_none) else $error("size without eeprom"); // R13
endmodule
`default_nettype wire

// ===== verif/mfrs_host_model.sv
// host model: object accesses and control word writes toward the selector
`timescale 1ns/1ns
`default_nettype none
module mfrs_host_model (
    input wire logic sys_clk,
    output mfrs_pkg::mfrs_req_t req,
    input wire logic ack,
    input wire logic err,
    input wire logic [31:0] rdata,
    output logic [15:0] ctrl_word
);
    // idle bus, quick-stop bit set in the control word
    initial begin
        req = '0;
        ctrl_word = 16'h000f;
    end
    // one access: one-cycle strobe, answer taken one cycle later
    task automatic access(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
        input logic [31:0] wd, output logic [31:0] rd, output logic e, output logic ok);
        @(posedge sys_clk);
        #1;
        req = '{rd: !wr, wr: wr, index: idx, subindex: sub, wdata: wd};
        @(posedge sys_clk);
        #1;
        ok = (ack === 1'b1);
        rd = rdata;
        e = err;
        // released lines no longer show the last value
        req = '{rd: 1'b0, wr: 1'b0, index: ~idx, subindex: ~sub, wdata: ~wd};
    endtask
    // leave quick-stop-active: bit 2 to 0, then back to 1
    task automatic qstop_release();
        @(posedge sys_clk);
        #1;
        ctrl_word[2] = 1'b0;
        @(posedge sys_clk);
        #1;
        ctrl_word[2] = 1'b1;
    endtask
endmodule
`default_nettype wire

// ===== verif/motion_fault_reaction_select_bench.sv
// bench for the fault reaction selector
`timescale 1ns/1ns
`default_nettype none
module motion_fault_reaction_select_bench;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    mfrs_pkg::mfrs_req_t req;
    logic ack, err, react_valid;
    logic [31:0] rdata, hw_config;
    logic deviation_err = 1'b0;
    logic limit_passed = 1'b0;
    logic eeprom_present = 1'b0;
    logic [31:0] eeprom_bytes = 32'h00000800;
    logic [15:0] ctrl_word_in, ctrl_word_out, status_out;
    logic [15:0] status_in = 16'h1234;
    logic warn_clear = 1'b0;
    mfrs_pkg::mfrs_react_t react;
    int num_errors = 0;
    int cmp_count = 0;

    // 250 MHz clock
    always #2 sys_clk = ~sys_clk;

    mfrs_top u_mfrs_top (.sys_clk(sys_clk), .rst_n(rst_n), .req(req), .ack(ack), .err(err),
        .rdata(rdata), .deviation_err(deviation_err), .limit_passed(limit_passed),
        .eeprom_present(eeprom_present), .eeprom_bytes(eeprom_bytes),
        .ctrl_word_in(ctrl_word_in), .ctrl_word_out(ctrl_word_out), .status_in(status_in),
        .status_out(status_out), .warn_clear(warn_clear), .react_valid(react_valid),
        .react(react), .hw_config(hw_config));
    mfrs_host_model u_mfrs_host_model (.sys_clk(sys_clk), .req(req), .ack(ack), .err(err),
        .rdata(rdata), .ctrl_word(ctrl_word_in));

    // compare and count
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    // access with expected read data and error flag
    task automatic acc(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
        input logic [31:0] wd, input logic [31:0] xrd, input logic xe);
        logic [31:0] rd;
        logic e, ok;
        u_mfrs_host_model.access(wr, idx, sub, wd, rd, e, ok);
        chk("ack", {31'h0, ok}, 32'h1);
        chk("err", {31'h0, e}, {31'h0, xe});
        if (!wr) chk("rdata", rd, xrd);
    endtask
    // set a code, raise one event, judge the reaction
    task automatic ev(input logic lim, input logic [15:0] code, input mfrs_pkg::mfrs_ramp_t rp,
        input mfrs_pkg::mfrs_next_t nx, input logic kp, input logic inv);
        int seen;
        seen = 0;
        acc(1'b1, lim ? mfrs_pkg::IDX_LIM_ACTION : mfrs_pkg::IDX_DEV_ACTION, 8'h00,
            {16'h0, code}, 32'h0, 1'b0);
        if (lim) limit_passed = 1'b1;
        else deviation_err = 1'b1;
        for (int i = 0; i < 8; i++) begin
            @(posedge sys_clk);
            #1;
            if (react_valid === 1'b1) seen++;
        end
        chk("valid", seen, inv ? 0 : 1);
        chk("invalid", {31'h0, react.invalid}, {31'h0, inv});
        if (!inv) chk("ramp", {30'h0, react.ramp}, {30'h0, rp});
        if (!inv) chk("next", {30'h0, react.next}, {30'h0, nx});
        if (!inv) chk("keep", {31'h0, react.keep_energized}, {31'h0, kp});
        chk("warn", {16'h0, status_out}, lim ? 32'h12b4 : 32'h1234);
        limit_passed = 1'b0;
        deviation_err = 1'b0;
        warn_clear = 1'b1;
        @(posedge sys_clk);
        #1;
        warn_clear = 1'b0;
        chk("warn_clr", {16'h0, status_out}, 32'h1234);
    endtask
    // reset values, write and read back, refused accesses
    task automatic t_regs();
        acc(1'b0, mfrs_pkg::IDX_DEV_ACTION, 8'h00, 32'h0, 32'hffffffff, 1'b0);
        acc(1'b0, mfrs_pkg::IDX_LIM_ACTION, 8'h00, 32'h0, 32'hffffffff, 1'b0);
        acc(1'b0, mfrs_pkg::IDX_HW_CONFIG, 8'h01, 32'h0, 32'h0, 1'b0);
        acc(1'b1, mfrs_pkg::IDX_DEV_ACTION, 8'h00, 32'h2, 32'h0, 1'b0);
        acc(1'b0, mfrs_pkg::IDX_DEV_ACTION, 8'h00, 32'h0, 32'h2, 1'b0);
        acc(1'b1, mfrs_pkg::IDX_DEV_ACTION, 8'h01, 32'h1, 32'h0, 1'b1);
        acc(1'b0, mfrs_pkg::IDX_DEV_ACTION, 8'h00, 32'h0, 32'h2, 1'b0);
        acc(1'b1, 16'h3702, 8'h00, 32'h1, 32'h0, 1'b1);
        acc(1'b0, 16'h3702, 8'h00, 32'h0, 32'h0, 1'b1);
        acc(1'b0, mfrs_pkg::IDX_HW_INFO, 8'h00, 32'h0, {24'h0, mfrs_pkg::HW_INFO_SUBS}, 1'b0);
        acc(1'b0, mfrs_pkg::IDX_HW_CONFIG, 8'h00, 32'h0, {24'h0, mfrs_pkg::HW_CONFIG_SUBS}, 1'b0);
        acc(1'b0, mfrs_pkg::IDX_HW_INFO, 8'h02, 32'h0, 32'h0, 1'b1);
        acc(1'b1, mfrs_pkg::IDX_HW_INFO, 8'h01, 32'h5, 32'h0, 1'b1);
        acc(1'b1, mfrs_pkg::IDX_HW_CONFIG, 8'h01, 32'ha5a5a5a5, 32'h0, 1'b0);
        acc(1'b0, mfrs_pkg::IDX_HW_CONFIG, 8'h01, 32'h0, 32'ha5a5a5a5, 1'b0);
        chk("hw_config", hw_config, 32'ha5a5a5a5);
    endtask
    // eeprom size, fitted and absent
    task automatic t_eeprom();
        eeprom_present = 1'b1;
        acc(1'b0, mfrs_pkg::IDX_HW_INFO, 8'h01, 32'h0, 32'h00000800, 1'b0);
        eeprom_present = 1'b0;
        acc(1'b0, mfrs_pkg::IDX_HW_INFO, 8'h01, 32'h0, 32'h0, 1'b0);
    endtask
    // quick-stop-active leaves the control word alone until the host toggles it
    task automatic t_qstop();
        ev(1'b1, 16'h0006, mfrs_pkg::MFRS_RAMP_QUICK, mfrs_pkg::MFRS_NEXT_QSTOP_ACT, 1'b1, 1'b0);
        chk("ctrl_hold", {16'h0, ctrl_word_out}, 32'h000f);
        u_mfrs_host_model.qstop_release();
        chk("ctrl_back", {16'h0, ctrl_word_out}, 32'h000f);
    endtask
    // verdict
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (3) @(posedge sys_clk);
        #1;
        rst_n = 1'b1;
        t_regs();
        t_eeprom();
        ev(1'b0, 16'h0000, mfrs_pkg::MFRS_RAMP_FREE, mfrs_pkg::MFRS_NEXT_STAY, 1'b0, 1'b0);
        ev(1'b0, 16'h0001, mfrs_pkg::MFRS_RAMP_SLOW, mfrs_pkg::MFRS_NEXT_STAY, 1'b0, 1'b0);
        ev(1'b0, 16'h0002, mfrs_pkg::MFRS_RAMP_QUICK, mfrs_pkg::MFRS_NEXT_STAY, 1'b0, 1'b0);
        ev(1'b0, 16'h0003, mfrs_pkg::MFRS_RAMP_NONE, mfrs_pkg::MFRS_NEXT_STAY, 1'b0, 1'b1);
        ev(1'b1, 16'hffff, mfrs_pkg::MFRS_RAMP_NONE, mfrs_pkg::MFRS_NEXT_STAY, 1'b1, 1'b0);
        ev(1'b1, 16'h0001, mfrs_pkg::MFRS_RAMP_SLOW, mfrs_pkg::MFRS_NEXT_SW_ON_DIS,
            1'b0, 1'b0);
        ev(1'b1, 16'h0002, mfrs_pkg::MFRS_RAMP_QUICK, mfrs_pkg::MFRS_NEXT_SW_ON_DIS,
            1'b0, 1'b0);
        ev(1'b1, 16'h0005, mfrs_pkg::MFRS_RAMP_SLOW, mfrs_pkg::MFRS_NEXT_QSTOP_ACT,
            1'b1, 1'b0);
        ev(1'b1, 16'h0003, mfrs_pkg::MFRS_RAMP_NONE, mfrs_pkg::MFRS_NEXT_STAY, 1'b0, 1'b1);
        t_qstop();
        summarize();
    end
endmodule
`default_nettype wire
